// File: param_channel_responder.sv
// Purpose: Responder of the four-word parameter channel, reached over APB
// Assumes: Software loads a small parameter table and condition flags
// Notes:   Every request yields one held response until the next request
//
// Design decisions made here: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`include "param_channel_map.svh"

module param_channel_responder
    import param_channel_pkg::*;
#(
    parameter int ENTRIES = 8
) (
    input  wire logic        CORE_CLK,
    input  wire logic        SYS_RST,
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic      [31:0] PRDATA,
    output logic             PREADY,
    output logic             PSLVERR,
    output logic             RSP_VALID
);

    localparam int IW = $clog2(ENTRIES);

    generate
        if (ENTRIES < 2 || ENTRIES > 256) begin : g_bad_entries
            $error("ENTRIES must lie between 2 and 256");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Storage

    // Table attributes per entry:
    // [15:0] full parameter number, [23:16] element count, [24] present,
    // [25] writable, [26] double word, [27] array, [28] reset only
    logic [31:0]  attr   [ENTRIES];
    logic [31:0]  value  [ENTRIES];
    logic [31:0]  lim    [ENTRIES];
    logic [IW-1:0] tab_idx;

    logic [15:0]  req_w0;
    logic [15:0]  req_w1;
    logic [31:0]  req_val;
    logic [15:0]  rsp_w0;
    logic [15:0]  rsp_w1;
    logic [31:0]  rsp_val;
    logic [7:0]   cond;
    logic         busy;
    resp_state_t  state;
    resp_state_t  next_state;

    ////////////////////////////////////////////////////////////////////////
    // APB decode

    wire acc    = PSEL & PENABLE;
    wire wr_acc = acc & PWRITE;
    wire hit_w0    = PADDR == `REQ_W0_OFS;
    wire hit_w1    = PADDR == `REQ_W1_OFS;
    wire hit_val   = PADDR == `REQ_VAL_OFS;
    wire hit_go    = PADDR == `REQ_GO_OFS;
    wire hit_rw0   = PADDR == `RSP_W0_OFS;
    wire hit_rw1   = PADDR == `RSP_W1_OFS;
    wire hit_rval  = PADDR == `RSP_VAL_OFS;
    wire hit_stat  = PADDR == `STATUS_OFS;
    wire hit_tidx  = PADDR == `TABLE_IDX_OFS;
    wire hit_tattr = PADDR == `TABLE_ATTR_OFS;
    wire hit_tdata = PADDR == `TABLE_DATA_OFS;
    wire hit_cond  = PADDR == `COND_OFS;
    wire mapped = hit_w0 | hit_w1 | hit_val | hit_go | hit_rw0 | hit_rw1 | hit_rval
                | hit_stat | hit_tidx | hit_tattr | hit_tdata | hit_cond;

    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        if (hit_w0)         rd_mux = {16'h0000, req_w0};
        else if (hit_w1)    rd_mux = {16'h0000, req_w1};
        else if (hit_val)   rd_mux = req_val;
        else if (hit_rw0)   rd_mux = {16'h0000, rsp_w0};
        else if (hit_rw1)   rd_mux = {16'h0000, rsp_w1};
        else if (hit_rval)  rd_mux = rsp_val;
        else if (hit_stat)  rd_mux = {30'h0, RSP_VALID, busy};
        else if (hit_tidx)  rd_mux = {{(32-IW){1'b0}}, tab_idx};
        else if (hit_tattr) rd_mux = attr[tab_idx];
        else if (hit_tdata) rd_mux = value[tab_idx];
        else if (hit_cond)  rd_mux = {24'h00_0000, cond};
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRDATA  <= 32'h0000_0000;
            PREADY  <= 1'b0;
            PSLVERR <= 1'b0;
        end else begin
            PREADY  <= PSEL & ~PENABLE;
            PSLVERR <= PSEL & ~PENABLE & ~mapped;
            PRDATA  <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : 32'h0000_0000;
        end
    end

    // Registered PREADY: access completes in the first cycle with PENABLE high, no wait state
    wire wr_take = wr_acc & PREADY;

    ////////////////////////////////////////////////////////////////////////
    // Request decode

    wire [3:0]  req_id   = req_w0[15:12];
    wire [10:0] param_number_field      = req_w0[10:0];
    wire [7:0]  sub_idx  = req_w1[15:8];
    wire [7:0]  page     = req_w1[7:0];

    // Page index to number offset
    function automatic logic [16:0] page_offset(input logic [7:0] p, output logic ok);
        ok = 1'b1;
        case (p)
            8'h00:   page_offset = 17'd0;
            8'h80:   page_offset = 17'd2000;
            8'h90:   page_offset = 17'd6000;
            8'h20:   page_offset = 17'd8000;
            8'hA0:   page_offset = 17'd10000;
            8'h50:   page_offset = 17'd20000;
            8'hF0:   page_offset = 17'd30000;
            8'h74:   page_offset = 17'd60000;
            default: begin
                page_offset = 17'd0;
                ok = 1'b0;
            end
        endcase
    endfunction

    logic        page_ok;
    logic [16:0] offs;
    always_comb begin
        page_ok = 1'b0;
        offs = page_offset(page, page_ok);
    end
    wire [16:0] full_num = offs + {6'h00, param_number_field};

    logic [ENTRIES-1:0] match;
    genvar g;
    generate
        for (g = 0; g < ENTRIES; g++) begin : g_match
            assign match[g] = attr[g][24] && ({1'b0, attr[g][15:0]} == full_num);
        end
    endgenerate

    logic [IW-1:0] sel;
    always_comb begin
        sel = '0;
        for (int i = ENTRIES - 1; i >= 0; i--) begin
            if (match[i]) sel = IW'(i);
        end
    end

    wire        found   = page_ok && (|match);
    wire [31:0] sa      = attr[sel];
    wire        s_wr    = sa[25];
    wire        s_dw    = sa[26];
    wire        s_arr   = sa[27];
    wire        s_rst   = sa[28];
    wire [7:0]  s_cnt   = sa[23:16];
    wire [31:0] s_lim   = lim[sel];
    wire        is_wr   = req_id == REQ_WRITE_W || req_id == REQ_WRITE_D
                        || req_id == REQ_WRITE_AW || req_id == REQ_WRITE_AD;
    wire        is_ar   = req_id == REQ_READ_ARR || req_id == REQ_WRITE_AW
                        || req_id == REQ_WRITE_AD;
    wire        wr_dw   = req_id == REQ_WRITE_D || req_id == REQ_WRITE_AD;
    wire        known   = req_id == REQ_NONE || req_id == REQ_READ || is_wr
                        || req_id == REQ_READ_DESC || req_id == REQ_READ_ARR
                        || req_id == REQ_COUNT;
    // Connector references keep both value words
    wire        conn    = req_val[15:10] == `CONNECTOR_TAG;
    wire [31:0] new_val = (wr_dw || conn) ? req_val : {16'h0000, req_val[15:0]};

    // Condition flags: [0] master control, [1] write authorised, [2] op state busy,
    // [3] controller enabled, [4] commissioning, [5] know-how lock, [6] keyword ok
    logic [15:0] err;
    logic        is_err;
    always_comb begin
        is_err = 1'b1;
        err    = `ERR_NO_PARAM;
        if (!known) err = `ERR_UNSUPPORTED;
        else if (!found) err = `ERR_NO_PARAM;
        else if (cond[5]) err = `ERR_KNOWHOW;
        else if (cond[2]) err = `ERR_OP_STATE;
        else if (sub_idx != 8'h00 && !s_arr) err = `ERR_NO_ARRAY;
        else if (s_arr && sub_idx >= s_cnt) err = `ERR_SUBINDEX;
        else if (req_id == REQ_READ_DESC && sub_idx > 8'h03) err = `ERR_SUBINDEX;
        else if (is_wr && !cond[0]) err = `ERR_NO_MASTER;
        else if (is_wr && !cond[6]) err = `ERR_KEYWORD;
        else if (is_wr && !s_wr) err = `ERR_READ_ONLY;
        else if (is_wr && cond[3]) err = `ERR_CTRL_ON;
        else if (is_wr && sa[29] && !cond[4]) err = `ERR_COMMISSION;
        else if (is_wr && wr_dw != s_dw) err = `ERR_DATA_TYPE;
        else if (is_wr && !wr_dw && req_val[31:16] != 16'h0000 && !conn)
            err = `ERR_CHAN_WIDTH;
        else if (is_wr && s_rst && new_val != 32'h0000_0000)
            err = `ERR_RESET_ONLY;
        else if (is_wr && new_val > s_lim) err = `ERR_ABOVE_LIM;
        else if (is_wr && sa[30] && new_val == s_lim) err = `ERR_VALUE_SET;
        else is_err = 1'b0;
    end
    // Remaining codes are kept for table attributes not yet mapped:
    // ERR_LIMIT ERR_DESC_FIXED ERR_ILLEGAL
    // ERR_BELOW_LIM and ERR_ACCESS_CODE have no attribute bit yet
    wire        deact = found && sa[31];
    wire [15:0] err_f = deact ? `ERR_DEACTIVATED : err;

    logic [3:0]  next_id;
    logic [31:0] next_val;
    always_comb begin
        next_val = 32'h0000_0000;
        next_id  = `RSP_NONE;
        if (is_wr && !cond[1] && known && found) begin
            next_id = `RSP_NO_MASTER;
        end else if (is_err || deact) begin
            next_id  = `RSP_ERROR;
            next_val = {err_f, 16'h0000};
        end else begin
            case (req_id)
                REQ_READ, REQ_WRITE_W, REQ_WRITE_D: begin
                    next_id  = s_dw ? `RSP_DWORD : `RSP_WORD;
                    next_val = value[sel];
                end
                REQ_READ_ARR, REQ_WRITE_AW, REQ_WRITE_AD: begin
                    next_id  = s_dw ? `RSP_ARR_DWORD : `RSP_ARR_WORD;
                    next_val = value[sel];
                end
                REQ_READ_DESC: begin
                    next_id  = `RSP_DESC;
                    next_val = (sub_idx == 8'h00) ? attr[sel] : lim[sel];
                end
                REQ_COUNT: begin
                    next_id  = `RSP_COUNT;
                    next_val = {24'h00_0000, s_cnt};
                end
                default: next_id = `RSP_NONE;
            endcase
            if (is_wr) next_val = new_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sequencer

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE:   if (wr_take && hit_go) next_state = ST_DECODE;
            ST_DECODE: next_state = ST_ANSWER;
            ST_ANSWER: next_state = ST_IDLE;
            default:   next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state     <= ST_IDLE;
            busy      <= 1'b0;
            RSP_VALID <= 1'b0;
            rsp_w0    <= 16'h0000;
            rsp_w1    <= 16'h0000;
            rsp_val   <= 32'h0000_0000;
        end else begin
            state <= next_state;
            busy  <= next_state != ST_IDLE;
            if (state == ST_IDLE && next_state == ST_DECODE) begin
                RSP_VALID <= 1'b0;
            end else if (state == ST_ANSWER) begin
                RSP_VALID <= 1'b1;
                rsp_w0    <= {next_id, 1'b0, param_number_field};
                rsp_w1    <= req_w1;
                rsp_val   <= next_val;
            end
        end
    end

    // Request words and table; writes ignored while a request is decoding
    always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            req_w0  <= 16'h0000;
            req_w1  <= 16'h0000;
            req_val <= 32'h0000_0000;
            tab_idx <= '0;
            cond    <= 8'h00;
            for (int i = 0; i < ENTRIES; i++) begin
                attr[i]  <= 32'h0000_0000;
                value[i] <= 32'h0000_0000;
                lim[i]   <= 32'hFFFF_FFFF;
            end
        end else if (state == ST_ANSWER && is_wr && !is_err && !deact && cond[1]) begin
            value[sel] <= new_val;
        end else if (wr_take && !busy) begin
            if (hit_w0)         req_w0  <= PWDATA[15:0];
            else if (hit_w1)    req_w1  <= PWDATA[15:0];
            else if (hit_val)   req_val <= PWDATA;
            else if (hit_tidx)  tab_idx <= PWDATA[IW-1:0];
            else if (hit_tattr) attr[tab_idx]  <= PWDATA;
            else if (hit_tdata) value[tab_idx] <= PWDATA;
            else if (hit_cond)  cond <= PWDATA[7:0];
            else if (hit_rval)  lim[tab_idx] <= PWDATA;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Checks

    AST_ERR_ID: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && (is_err || deact) && !(is_wr && !cond[1])
        |=> rsp_w0[15:12] == `RSP_ERROR && rsp_val[15:0] == 16'h0000)
        else $error("error answer lacks id 7");
    AST_NOMASTER: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && is_wr && known && found && !cond[1]
        |=> rsp_w0[15:12] == `RSP_NO_MASTER)
        else $error("no-authorisation answer lacks id 8");
    AST_UNSUP: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && !known |=> rsp_val[31:16] == `ERR_UNSUPPORTED)
        else $error("unsupported request not flagged");
    AST_ONE_RESP: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        $rose(RSP_VALID) |-> $past(state, 1) == ST_ANSWER)
        else $error("response raised outside answer step");
    AST_HOLD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        RSP_VALID && state == ST_IDLE && !(wr_take && hit_go) |=> $stable(rsp_w0))
        else $error("held response changed");
    AST_LATENCY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_IDLE && wr_take && hit_go |-> ##3 RSP_VALID)
        else $error("response not ready in three cycles");
    AST_BIT11: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        RSP_VALID |-> rsp_w0[11] == 1'b0)
        else $error("response bit 11 set");
    AST_COUNT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && req_id == REQ_COUNT && !is_err && !deact
        |=> rsp_w0[15:12] == `RSP_COUNT && rsp_val[7:0] == $past(s_cnt))
        else $error("count answer wrong");
    AST_ARRAY: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && req_id == REQ_READ_ARR && !is_err && !deact
        |=> rsp_w0[15:12] == ($past(s_dw) ? `RSP_ARR_DWORD : `RSP_ARR_WORD))
        else $error("array answer id wrong");
    AST_ECHO: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER |=> rsp_w1 == $past(req_w1) && rsp_w0[10:0] == $past(param_number_field))
        else $error("response does not echo the request");
    AST_VAL_HOLD: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        RSP_VALID && state == ST_IDLE |=> $stable(rsp_val) && $stable(rsp_w1))
        else $error("held response value changed");
    AST_BUSY_LOW: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state != ST_IDLE |-> !RSP_VALID && busy)
        else $error("response shown while a request is decoding");
    AST_NOPARAM: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && known && !found
        |=> rsp_w0[15:12] == `RSP_ERROR && rsp_val[31:16] == `ERR_NO_PARAM)
        else $error("missing parameter not reported");
    AST_DEACT: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && deact && !is_wr |=> rsp_val[31:16] == `ERR_DEACTIVATED)
        else $error("deactivated parameter not reported");
    AST_KNOWHOW: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && known && found && !deact && cond[5] && cond[1]
        |=> rsp_val[31:16] == `ERR_KNOWHOW)
        else $error("know-how lock not reported");
    AST_WORD_ID: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && req_id == REQ_READ && !is_err && !deact
        |=> rsp_w0[15:12] == ($past(s_dw) ? `RSP_DWORD : `RSP_WORD))
        else $error("value answer id wrong");
    AST_DESC: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && req_id == REQ_READ_DESC && !is_err && !deact
        |=> rsp_w0[15:12] == `RSP_DESC)
        else $error("descriptor answer id wrong");
    AST_STORE: assert property (@(posedge CORE_CLK) disable iff (SYS_RST)
        state == ST_ANSWER && is_wr && !is_err && !deact && cond[1]
        |=> value[$past(sel)] == $past(new_val))
        else $error("accepted write not stored");

endmodule // param_channel_responder

// File: param_channel_map.svh
// Purpose: Constants for the parameter channel responder
// Assumes: Four 16-bit channel words, APB register access
// Notes:   Offsets are byte addresses of 32-bit registers
//
// Behaviour
// - Response id 0 none, 1 word, 2 double word, 3 descriptor, 6 element count.
// - Array element answers use id 4 for word, 5 for double word.
// - Unprocessable request answers id 7 with error number in top word.
// - Missing authorisation answers id 8; missing master control answers id 7 with error 0B.
// - Subindex in the index word is range-checked and picks attribute or limit in descriptor reads; all array elements share one table value.
// - Error 00 for missing parameter, 01 for unchangeable value.
// - Error 02 for a value outside limits.
// - Error 03 for missing subindex, 04 for subindex on non-array.
// - Error 05 for data type mismatch.
// - Error 06 for nonzero write to reset-only, 07 for fixed descriptor.
// - Error 0B for change without master control, 0C for missing keyword.
// - Error 11 when operating state temporarily blocks access.
// - Error 14 for permanently illegal value, 68 for restricted value set.
// - Error 65 for deactivated parameter, 66 for channel too small.
// - Error 6A for unsupported request id, 6B when controller blocks change.
// - Error 86 for commissioning-only write, 87 for know-how lock.
// - Error C8 below lower limit, C9 above limit, CC missing access code.
// - Higher numbers carry number minus offset, page index gives offset code.
// - 8-bit, 16-bit and 32-bit values pack into the value words.
// - Connector: number in third word, 3F and index in fourth word.
// - Channel is four 16-bit words; bits 15 to 12 hold identifier.
`ifndef PARAM_CHANNEL_MAP_SVH
`define PARAM_CHANNEL_MAP_SVH

`define REQ_W0_OFS      12'h000
`define REQ_W1_OFS      12'h004
`define REQ_VAL_OFS     12'h008
`define REQ_GO_OFS      12'h00C
`define RSP_W0_OFS      12'h010
`define RSP_W1_OFS      12'h014
`define RSP_VAL_OFS     12'h018
`define STATUS_OFS      12'h01C
`define TABLE_IDX_OFS   12'h020
`define TABLE_ATTR_OFS  12'h024
`define TABLE_DATA_OFS  12'h028
`define COND_OFS        12'h02C

`define RSP_NONE        4'h0
`define RSP_WORD        4'h1
`define RSP_DWORD       4'h2
`define RSP_DESC        4'h3
`define RSP_ARR_WORD    4'h4
`define RSP_ARR_DWORD   4'h5
`define RSP_COUNT       4'h6
`define RSP_ERROR       4'h7
`define RSP_NO_MASTER   4'h8

`define ERR_NO_PARAM    16'h0000
`define ERR_READ_ONLY   16'h0001
`define ERR_LIMIT       16'h0002
`define ERR_SUBINDEX    16'h0003
`define ERR_NO_ARRAY    16'h0004
`define ERR_DATA_TYPE   16'h0005
`define ERR_RESET_ONLY  16'h0006
`define ERR_DESC_FIXED  16'h0007
`define ERR_NO_MASTER   16'h000B
`define ERR_KEYWORD     16'h000C
`define ERR_OP_STATE    16'h0011
`define ERR_ILLEGAL     16'h0014
`define ERR_DEACTIVATED 16'h0065
`define ERR_CHAN_WIDTH  16'h0066
`define ERR_VALUE_SET   16'h0068
`define ERR_UNSUPPORTED 16'h006A
`define ERR_CTRL_ON     16'h006B
`define ERR_COMMISSION  16'h0086
`define ERR_KNOWHOW     16'h0087
`define ERR_BELOW_LIM   16'h00C8
`define ERR_ABOVE_LIM   16'h00C9
`define ERR_ACCESS_CODE 16'h00CC

`define CONNECTOR_TAG   6'h3F

`endif

// File: param_channel_pkg.sv
// Purpose: Types for the parameter channel responder
// Assumes: Constants live in param_channel_map.svh
// Notes:   Request ids follow the controller-side coding
package param_channel_pkg;
    typedef enum logic [3:0] {
        REQ_NONE       = 4'h0,
        REQ_READ       = 4'h1,
        REQ_WRITE_W    = 4'h2,
        REQ_WRITE_D    = 4'h3,
        REQ_READ_DESC  = 4'h4,
        REQ_READ_ARR   = 4'h6,
        REQ_WRITE_AW   = 4'h7,
        REQ_WRITE_AD   = 4'h8,
        REQ_COUNT      = 4'h9
    } req_id_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b001,
        ST_DECODE = 3'b010,
        ST_ANSWER = 3'b100
    } resp_state_t;
endpackage

// File: param_channel_controller.sv
// Purpose: Controller model that drives the parameter channel over APB
// Assumes: Responder raises PREADY for every access
// Notes:   Channel words are built from a full parameter number
`timescale 1ns/1ps
`include "param_channel_map.svh"

module param_channel_controller (
    input  wire logic        clk,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    input  wire logic        pslverr,
    output logic             psel,
    output logic             penable,
    output logic             pwrite,
    output logic      [11:0] paddr,
    output logic      [31:0] pwdata
);
    logic rerr;

    initial begin
        psel    = 1'b0;
        penable = 1'b0;
        pwrite  = 1'b0;
        paddr   = 12'h000;
        pwdata  = 32'h0000_0000;
        rerr    = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        q       = prdata;
        rerr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        // Released data lines must not keep the last value
        pwdata  <= ~d;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic request(input logic [3:0] id, input int num, input logic [7:0] sub,
                           input logic [31:0] val, output logic [15:0] w0,
                           output logic [15:0] w1);
        int          base[7] = '{2000, 6000, 8000, 10000, 20000, 30000, 60000};
        logic [7:0]  code[7] = '{8'h80, 8'h90, 8'h20, 8'hA0, 8'h50, 8'hF0, 8'h74};
        int          ofs;
        logic [7:0]  page;
        logic [31:0] q;
        ofs  = 0;
        page = 8'h00;
        for (int i = 0; i < 7; i++) begin
            if (num >= base[i]) begin
                ofs  = base[i];
                page = code[i];
            end
        end
        w0 = {id, 1'b0, 11'(num - ofs)};
        w1 = {sub, page};
        xfer(1'b1, `REQ_W0_OFS, {16'h0000, w0}, q);
        xfer(1'b1, `REQ_W1_OFS, {16'h0000, w1}, q);
        xfer(1'b1, `REQ_VAL_OFS, val, q);
        xfer(1'b1, `REQ_GO_OFS, 32'h0000_0001, q);
        q = 32'h0000_0000;
        for (int i = 0; i < 20 && q[1] !== 1'b1; i++) begin
            xfer(1'b0, `STATUS_OFS, 32'h0000_0000, q);
        end
    endtask
endmodule // param_channel_controller

// File: test_param_channel_responder.sv
// Purpose: Self-checking bench of the parameter channel responder
// Assumes: Controller model issues all APB traffic
// Notes:   Expected responses are built from the channel coding
`timescale 1ns/1ps
`include "param_channel_map.svh"

module test_param_channel_responder;
    import param_channel_pkg::*;

    logic        core_clk;
    logic        sys_rst;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        rsp_valid;
    logic [31:0] d;
    int          miscompares;
    int          num_checks;
    logic [7:0]  cnd[5] = '{8'h47, 8'h4B, 8'h63, 8'h03, 8'h42};
    logic [15:0] err[5] = '{`ERR_OP_STATE, `ERR_CTRL_ON, `ERR_KNOWHOW, `ERR_KEYWORD,
                            `ERR_NO_MASTER};

    param_channel_responder #(.ENTRIES(8)) dut (
        .CORE_CLK(core_clk), .SYS_RST(sys_rst), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
        .PREADY(pready), .PSLVERR(pslverr), .RSP_VALID(rsp_valid)
    );

    param_channel_controller ctl (
        .clk(core_clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
    );

    always #2 core_clk = ~core_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        logic [31:0] q;
        ctl.xfer(1'b1, a, v, q);
    endtask

    task automatic entry(input logic [31:0] idx, input logic [31:0] attr, input logic [31:0] v);
        wr(`TABLE_IDX_OFS, idx);
        wr(`TABLE_ATTR_OFS, attr);
        wr(`TABLE_DATA_OFS, v);
    endtask

    // One request, then the held response is read back and compared
    task automatic run(input logic [3:0] id, input int num, input logic [7:0] sub,
                       input logic [31:0] val, input logic [3:0] eid, input bit cv,
                       input logic [31:0] ev);
        logic [15:0] w0;
        logic [15:0] w1;
        logic [31:0] q;
        ctl.request(id, num, sub, val, w0, w1);
        check("rsp_valid", 32'h1, {31'h0, rsp_valid});
        ctl.xfer(1'b0, `RSP_W0_OFS, 32'h0, q);
        check("rsp_w0", {16'h0, eid, w0[11:0]}, q);
        ctl.xfer(1'b0, `RSP_W1_OFS, 32'h0, q);
        check("rsp_w1", {16'h0, w1}, q);
        ctl.xfer(1'b0, `RSP_VAL_OFS, 32'h0, q);
        if (cv) check("rsp_val", ev, q);
        check("rsp_held", 32'h1, {31'h0, rsp_valid});
    endtask

    task automatic results();
        if (miscompares == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6000) @(posedge core_clk);
        miscompares++;
        results();
    end

    initial begin
        core_clk    = 1'b0;
        sys_rst     = 1'b1;
        miscompares = 0;
        num_checks  = 0;
        repeat (6) @(posedge core_clk);
        sys_rst <= 1'b0;
        @(posedge core_clk);
        check("valid_rst", 32'h0, {31'h0, rsp_valid});
        ctl.xfer(1'b0, `STATUS_OFS, 32'h0, d);
        check("status_rst", 32'h0, d);
        check("pslverr_ok", 32'h0, {31'h0, ctl.rerr});
        ctl.xfer(1'b0, 12'h030, 32'h0, d);
        check("pslverr", 32'h1, {31'h0, ctl.rerr});
        entry(0, 32'h0300_04BA, 32'h0);
        entry(1, 32'h0D04_1EA1, 32'h1234_5678);
        entry(2, 32'h0B03_0348, 32'h0);
        entry(3, 32'h1300_EA65, 32'h0);
        entry(4, 32'h2300_0834, 32'h0);
        entry(5, 32'h8100_1F41, 32'h0);
        entry(6, 32'h4300_2710, 32'h0);
        wr(`RSP_VAL_OFS, 32'h7);
        wr(`COND_OFS, 32'h43);
        run(4'h1, 1210, 8'h0, 32'h0, `RSP_WORD, 1, 32'h0);
        run(4'h2, 1210, 8'h0, 32'h1A, `RSP_WORD, 1, 32'h1A);
        run(4'h1, 1210, 8'h0, 32'h0, `RSP_WORD, 1, 32'h1A);
        run(4'h4, 1210, 8'h0, 32'h0, `RSP_DESC, 1, 32'h0300_04BA);
        run(4'h1, 1210, 8'h1, 32'h0, `RSP_ERROR, 1, {`ERR_NO_ARRAY, 16'h0});
        run(4'h6, 7841, 8'h2, 32'h0, `RSP_ARR_DWORD, 1, 32'h1234_5678);
        run(4'h6, 7841, 8'h4, 32'h0, `RSP_ERROR, 1, {`ERR_SUBINDEX, 16'h0});
        run(4'h9, 7841, 8'h0, 32'h0, `RSP_COUNT, 1, 32'h4);
        run(4'h1, 1999, 8'h0, 32'h0, `RSP_ERROR, 1, {`ERR_NO_PARAM, 16'h0});
        run(4'h8, 7841, 8'h0, 32'h1, `RSP_ERROR, 1, {`ERR_READ_ONLY, 16'h0});
        run(4'h5, 1210, 8'h0, 32'h0, `RSP_ERROR, 1, {`ERR_UNSUPPORTED, 16'h0});
        run(4'h3, 1210, 8'h0, 32'h1, `RSP_ERROR, 1, {`ERR_DATA_TYPE, 16'h0});
        run(4'h7, 840, 8'h1, 32'h02D2_FC02, `RSP_ARR_WORD, 1, 32'h02D2_FC02);
        run(4'h2, 1210, 8'h0, 32'h0001_0005, `RSP_ERROR, 1, {`ERR_CHAN_WIDTH, 16'h0});
        run(4'h2, 60005, 8'h0, 32'h5, `RSP_ERROR, 1, {`ERR_RESET_ONLY, 16'h0});
        run(4'h2, 60005, 8'h0, 32'h0, `RSP_WORD, 1, 32'h0);
        run(4'h2, 2100, 8'h0, 32'h1, `RSP_ERROR, 1, {`ERR_COMMISSION, 16'h0});
        run(4'h1, 8001, 8'h0, 32'h0, `RSP_ERROR, 1, {`ERR_DEACTIVATED, 16'h0});
        run(4'h2, 10000, 8'h0, 32'h7, `RSP_ERROR, 1, {`ERR_VALUE_SET, 16'h0});
        wr(`TABLE_IDX_OFS, 32'h0);
        wr(`RSP_VAL_OFS, 32'h64);
        run(4'h2, 1210, 8'h0, 32'h65, `RSP_ERROR, 1, {`ERR_ABOVE_LIM, 16'h0});
        run(4'h2, 1210, 8'h0, 32'h64, `RSP_WORD, 1, 32'h64);
        for (int i = 0; i < 5; i++) begin
            wr(`COND_OFS, {24'h0, cnd[i]});
            run(4'h2, 1210, 8'h0, 32'h1A, `RSP_ERROR, 1, {err[i], 16'h0});
        end
        wr(`COND_OFS, 32'h41);
        run(4'h2, 1210, 8'h0, 32'h1A, `RSP_NO_MASTER, 0, 32'h0);
        results();
    end
endmodule // test_param_channel_responder
